// file: test/tmo_assertions.sv
// Checker watching the link between the ordering unit and the memory side.
`timescale 1ns/1ps
`default_nettype none
module tmo_assertions (
  input wire logic                       clk_in,
  input wire logic                       resetn_in,
  input wire logic                       d_req,
  input wire logic [1:0]                 d_op,
  input wire logic [tmo_pkg::TAG_W-1:0]  d_tag,
  input wire logic [tmo_pkg::ADDR_W-1:0] d_addr,
  input wire logic                       d_acc,
  input wire logic                       d_done,
  input wire logic [tmo_pkg::TAG_W-1:0]  d_done_tag,
  input wire logic                       i_req,
  input wire logic                       i_done,
  input wire logic                       strands_paused
);
  logic [2:0] pend_q;
  logic       held_q;
  logic       new_req;
  // A held request is not a new one, so order checks fire once per transfer.
  assign new_req = d_req && !held_q;
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pend_q <= 3'h0;
      held_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_q + 3'(d_acc) - 3'(d_done);
      held_q <= d_req && !d_acc;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  a_req_held: assert property (d_req && !d_acc |=> d_req && $stable(d_addr) && $stable(d_tag))
    else $error("request changed before accept");
  a_acc_bounded: assert property (new_req |-> ##[1:8] d_acc)
    else $error("request not accepted in time");
  a_done_tagged: assert property (d_acc |-> ##2 (d_done && d_done_tag == $past(d_tag, 2)))
    else $error("completion late or with wrong tag");
  a_mem_serial: assert property (d_acc |-> pend_q <= 3'(d_done))
    else $error("memory overlaps two transactions");
  a_store_waits: assert property (new_req && d_op != tmo_pkg::OP_LOAD |-> pend_q == 3'h0)
    else $error("store or atomic issued with work pending");
  a_data_path_op: assert property (d_req |-> d_op != tmo_pkg::OP_IFETCH)
    else $error("fetch sent on data path");
  a_fetch_answer: assert property (i_req |-> ##[1:8] i_done)
    else $error("fetch not answered");
  a_pause_drained: assert property ($rose(strands_paused) |-> pend_q == 3'h0 && !d_req)
    else $error("strands paused before drain");
  a_pause_ends: assert property ($rose(strands_paused) |-> ##[1:30] !strands_paused)
    else $error("strands never resumed");
  c_atomic: cover property (d_acc && d_op == tmo_pkg::OP_ATOMIC);
  c_paused: cover property ($rose(strands_paused));
  c_fetch: cover property (i_done);
endmodule
`default_nettype wire

// file: test/tso_memory_ordering_unit_test.sv
// Testbench driving the ordering unit against the memory side, with a scoreboard.
`timescale 1ns/1ps
`default_nettype none
module tso_memory_ordering_unit_test;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        mm_wr_in = 1'b0;
  logic [1:0]  mm_wdata_in = 2'h0;
  logic        op_valid_in = 1'b0;
  logic [1:0]  op_kind_in = 2'h0;
  logic [31:0] op_addr_in = 32'h0000_0000;
  logic [31:0] op_wdata_in = 32'h0000_0000;
  logic [3:0]  flags = 4'h0;
  logic        fetch_in = 1'b0;
  logic [31:0] fetch_addr_in = 32'h0000_0000;
  logic [1:0]  memory_model_select_out;
  logic        op_ready_out, op_fault_out, load_done_out, fetch_done_out;
  logic [31:0] load_data_out, fetch_data_out, probe_data_out;
  logic [31:0] model_mem [16];
  logic [31:0] load_q [$];
  logic [31:0] fetch_q [$];
  int          fail_count = 0;
  int          n_tests = 0;
  tmo_mem_if mem_if ();
  tmo_order_unit tmo_order_unit_i (.clk_in(clk_in), .resetn_in(resetn_in), .mem(mem_if),
    .mm_wr_in(mm_wr_in), .mm_wdata_in(mm_wdata_in),
    .memory_model_select_out(memory_model_select_out), .op_valid_in(op_valid_in),
    .op_kind_in(op_kind_in), .op_addr_in(op_addr_in), .op_wdata_in(op_wdata_in),
    .op_cacheable_in(flags[3]), .op_side_effect_in(flags[2]),
    .store_to_load_barrier_in(flags[1]), .op_internal_asi_in(flags[0]),
    .op_ready_out(op_ready_out), .op_fault_out(op_fault_out), .load_done_out(load_done_out),
    .load_data_out(load_data_out), .fetch_in(fetch_in), .fetch_addr_in(fetch_addr_in),
    .fetch_done_out(fetch_done_out), .fetch_data_out(fetch_data_out));
  tmo_mem_side tmo_mem_side_i (.clk_in(clk_in), .resetn_in(resetn_in), .mem(mem_if),
    .probe_data_out(probe_data_out));
  tmo_assertions tmo_assertions_i (.clk_in(clk_in), .resetn_in(resetn_in),
    .d_req(mem_if.d_req), .d_op(mem_if.d_op), .d_tag(mem_if.d_tag), .d_addr(mem_if.d_addr),
    .d_acc(mem_if.d_acc), .d_done(mem_if.d_done), .d_done_tag(mem_if.d_done_tag),
    .i_req(mem_if.i_req), .i_done(mem_if.i_done), .strands_paused(mem_if.strands_paused));
  always #4 clk_in = ~clk_in;
  task automatic compare_data(input logic [31:0] exp_v, input logic [31:0] got_v);
    n_tests++;
    if (got_v !== exp_v)
    begin
      fail_count++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp_v, got_v);
    end
  endtask
  task automatic compare_flag(input logic exp_v, input logic got_v);
    compare_data(32'(exp_v), 32'(got_v));
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Flags are cacheable, side effect, barrier, internal space, from the top bit down.
  task automatic do_op(input logic [1:0] kind, input logic [3:0] idx, input logic [31:0] wd,
                       input logic [3:0] fl);
    int n;
    logic ok;
    @(negedge clk_in);
    ok = kind != tmo_pkg::OP_ATOMIC || fl[3];
    if (kind != tmo_pkg::OP_STORE && ok)
      load_q.push_back(model_mem[idx]);
    if (kind == tmo_pkg::OP_STORE)
      model_mem[idx] = wd;
    else if (kind == tmo_pkg::OP_ATOMIC && ok)
      model_mem[idx] = wd;
    op_valid_in = 1'b1;
    op_kind_in = kind;
    op_addr_in = {26'h0, idx, 2'h0};
    op_wdata_in = wd;
    flags = fl;
    n = 0;
    do
    begin
      @(negedge clk_in);
      n++;
    end
    while (op_ready_out !== 1'b1 && n < 60);
    compare_flag(1'b1, op_ready_out);
    compare_flag(!ok, op_fault_out);
    op_valid_in = 1'b0;
  endtask
  task automatic set_model(input logic [1:0] w);
    @(negedge clk_in);
    mm_wr_in = 1'b1;
    mm_wdata_in = w;
    @(negedge clk_in);
    mm_wr_in = 1'b0;
    compare_data(32'(w == tmo_pkg::MM_RELAXED_ORDERING_MODEL ? w : 2'h0),
                 32'(memory_model_select_out));
    do_op(tmo_pkg::OP_STORE, 4'h3, $urandom, 4'h8);
    do_op(tmo_pkg::OP_LOAD, 4'h3, 32'h0000_0000, 4'h8);
  endtask
  always @(negedge clk_in)
  begin
    if (load_done_out === 1'b1 && load_q.size() == 0)
      compare_flag(1'b0, load_done_out);
    else if (load_done_out === 1'b1)
      compare_data(load_q.pop_front(), load_data_out);
    if (fetch_done_out === 1'b1 && fetch_q.size() == 0)
      compare_flag(1'b0, fetch_done_out);
    else if (fetch_done_out === 1'b1)
      compare_data(fetch_q.pop_front(), fetch_data_out);
  end
  initial
  begin
    #(20000 * 8);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(80));
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    compare_data(32'(tmo_pkg::MM_RESET), 32'(memory_model_select_out));
    for (int i = 0; i < 16; i++)
      do_op(tmo_pkg::OP_STORE, 4'(i), $urandom, 4'h8);
    for (int w = 0; w < 4; w++)
      set_model(2'(w));
    set_model(tmo_pkg::MM_TSO);
    for (int i = 0; i < 40; i++)
      do_op(2'($urandom_range(1, 0)), 4'($urandom), $urandom, 4'($urandom) & 4'hE);
    do_op(tmo_pkg::OP_ATOMIC, 4'h5, $urandom, 4'h8);
    do_op(tmo_pkg::OP_LOAD, 4'h5, 32'h0000_0000, 4'h8);
    do_op(tmo_pkg::OP_STORE, 4'h5, $urandom, 4'h8);
    do_op(tmo_pkg::OP_ATOMIC, 4'h6, $urandom, 4'h0);
    do_op(tmo_pkg::OP_LOAD, 4'h6, 32'h0000_0000, 4'h8);
    do_op(tmo_pkg::OP_STORE, 4'h7, $urandom, 4'h9);
    do_op(tmo_pkg::OP_LOAD, 4'h7, 32'h0000_0000, 4'h9);
    do_op(tmo_pkg::OP_STORE, 4'h9, $urandom, 4'h0);
    do_op(tmo_pkg::OP_LOAD, 4'h9, 32'h0000_0000, 4'h0);
    do_op(tmo_pkg::OP_STORE, 4'hA, $urandom, 4'h8);
    do_op(tmo_pkg::OP_LOAD, 4'hA, 32'h0000_0000, 4'hA);
    for (int i = 0; i < 4; i++)
      do_op(2'(i & 1), 4'hB, $urandom, 4'h4);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk_in);
      fetch_q.push_back(model_mem[i * 3]);
      fetch_in = 1'b1;
      fetch_addr_in = {26'h0, 4'(i * 3), 2'h0};
      @(negedge clk_in);
      fetch_in = 1'b0;
      repeat (10) @(negedge clk_in);
    end
    repeat (20) @(negedge clk_in);
    compare_data(model_mem[0], probe_data_out);
    compare_data(32'h0000_0000, 32'(load_q.size() + fetch_q.size()));
    print_verdict();
  end
endmodule
`default_nettype wire

// file: verilog/tmo_mem_if.sv
// Interface joining the ordering unit to the coherent memory side.
`timescale 1ns/1ps
`default_nettype none
interface tmo_mem_if;
  logic                        d_req;
  logic [1:0]                  d_op;
  logic [tmo_pkg::TAG_W-1:0]   d_tag;
  logic [tmo_pkg::ADDR_W-1:0]  d_addr;
  logic [tmo_pkg::DATA_W-1:0]  d_wdata;
  logic                        d_acc;
  logic                        d_done;
  logic [tmo_pkg::TAG_W-1:0]   d_done_tag;
  logic [tmo_pkg::DATA_W-1:0]  d_rdata;
  logic                        i_req;
  logic [tmo_pkg::ADDR_W-1:0]  i_addr;
  logic                        i_done;
  logic [tmo_pkg::DATA_W-1:0]  i_rdata;
  logic                        strands_paused;
  modport dev (
    output d_req, d_op, d_tag, d_addr, d_wdata, i_req, i_addr, strands_paused,
    input  d_acc, d_done, d_done_tag, d_rdata, i_done, i_rdata
  );
  modport mem (
    input  d_req, d_op, d_tag, d_addr, d_wdata, i_req, i_addr, strands_paused,
    output d_acc, d_done, d_done_tag, d_rdata, i_done, i_rdata
  );
endinterface
`default_nettype wire

// file: verilog/tmo_mem_side.sv
// Memory end: accepts transactions, performs them atomically, completes them.
`timescale 1ns/1ps
`default_nettype none
module tmo_mem_side (
  input  wire logic    clk_in,
  input  wire logic    resetn_in,
  tmo_mem_if.mem       mem,
  output logic [tmo_pkg::DATA_W-1:0] probe_data_out
);
  typedef struct packed {
    logic [tmo_pkg::MEM_WORDS-1:0][tmo_pkg::DATA_W-1:0] word;
    logic                        busy;
    logic [1:0]                  lat;
    logic [1:0]                  op;
    logic [tmo_pkg::TAG_W-1:0]   tag;
    logic [tmo_pkg::MEM_IDX_W-1:0] idx;
    logic [tmo_pkg::DATA_W-1:0]  wdata;
    logic                        acc;
    logic                        done;
    logic [tmo_pkg::TAG_W-1:0]   done_tag;
    logic [tmo_pkg::DATA_W-1:0]  rdata;
    logic                        i_done;
    logic [tmo_pkg::DATA_W-1:0]  i_rdata;
    logic [tmo_pkg::DATA_W-1:0]  probe;
  } tmo_ms_t;
  tmo_ms_t s_q;
  tmo_ms_t s_d;
  always_comb
  begin
    s_d = s_q;
    s_d.acc = 1'b0;
    s_d.done = 1'b0;
    s_d.i_done = 1'b0;
    // Accept only when idle; one location update at a time gives a total order.
    if (!s_q.busy && mem.d_req && !s_q.acc)
    begin
      s_d.acc = 1'b1;
      s_d.busy = 1'b1;
      s_d.lat = tmo_pkg::LAT_RESET;
      s_d.op = mem.d_op;
      s_d.tag = mem.d_tag;
      s_d.idx = mem.d_addr[tmo_pkg::MEM_IDX_W+1:2];
      s_d.wdata = mem.d_wdata;
    end
    else if (s_q.busy)
    begin
      s_d.lat = s_q.lat + 2'h1;
      if (s_q.lat == 2'(tmo_pkg::MEM_LAT_CYC - 1))
      begin
        // Read and write land in one cycle, so every observer sees one value.
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.done_tag = s_q.tag;
        s_d.rdata = s_q.word[s_q.idx];
        if (s_q.op != tmo_pkg::OP_LOAD)
        begin
          s_d.word[s_q.idx] = s_q.wdata;
        end
      end
    end
    if (mem.i_req)
    begin
      s_d.i_done = 1'b1;
      s_d.i_rdata = s_q.word[mem.i_addr[tmo_pkg::MEM_IDX_W+1:2]];
    end
    s_d.probe = s_q.word[0];
  end
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign mem.d_acc = s_q.acc;
  assign mem.d_done = s_q.done;
  assign mem.d_done_tag = s_q.done_tag;
  assign mem.d_rdata = s_q.rdata;
  assign mem.i_done = s_q.i_done;
  assign mem.i_rdata = s_q.i_rdata;
  assign probe_data_out = s_q.probe;
endmodule
`default_nettype wire

// file: verilog/tmo_order_unit.sv
// Strand end: orders loads, stores and atomics under the selected model.
`timescale 1ns/1ps
`default_nettype none
module tmo_order_unit (
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  tmo_mem_if.dev                           mem,
  input  wire logic                        mm_wr_in,
  input  wire logic [1:0]                  mm_wdata_in,
  output logic [1:0]                       memory_model_select_out,
  input  wire logic                        op_valid_in,
  input  wire logic [1:0]                  op_kind_in,
  input  wire logic [tmo_pkg::ADDR_W-1:0]  op_addr_in,
  input  wire logic [tmo_pkg::DATA_W-1:0]  op_wdata_in,
  input  wire logic                        op_cacheable_in,
  input  wire logic                        op_side_effect_in,
  input  wire logic                        store_to_load_barrier_in,
  input  wire logic                        op_internal_asi_in,
  output logic                             op_ready_out,
  output logic                             op_fault_out,
  output logic                             load_done_out,
  output logic [tmo_pkg::DATA_W-1:0]       load_data_out,
  input  wire logic                        fetch_in,
  input  wire logic [tmo_pkg::ADDR_W-1:0]  fetch_addr_in,
  output logic                             fetch_done_out,
  output logic [tmo_pkg::DATA_W-1:0]       fetch_data_out
);
  typedef struct packed {
    tmo_pkg::tmo_state_t         st;
    logic [1:0]                  mm;
    logic [tmo_pkg::NTAG-1:0]    pend;
    logic [tmo_pkg::NTAG-1:0]    pend_ld;
    logic [tmo_pkg::NTAG-1:0]    pend_se;
    logic [tmo_pkg::TAG_W-1:0]   next_tag;
    logic                        req;
    logic [1:0]                  op;
    logic [tmo_pkg::TAG_W-1:0]   tag;
    logic [tmo_pkg::ADDR_W-1:0]  addr;
    logic [tmo_pkg::DATA_W-1:0]  wdata;
    logic                        req_ld;
    logic                        req_se;
    logic                        ready;
    logic                        fault;
    logic                        ld_done;
    logic [tmo_pkg::DATA_W-1:0]  ld_data;
    logic                        i_req;
    logic [tmo_pkg::ADDR_W-1:0]  i_addr;
    logic                        f_done;
    logic [tmo_pkg::DATA_W-1:0]  f_data;
    logic                        paused;
  } tmo_ou_t;
  tmo_ou_t s_q;
  tmo_ou_t s_d;

  function automatic logic [tmo_pkg::NTAG-1:0] tag_bit(input logic [tmo_pkg::TAG_W-1:0] t);
    tag_bit = tmo_pkg::NTAG'(1) << t;
  endfunction

  function automatic logic [1:0] mm_legal(input logic [1:0] w);
    // Unsupported codes fall to TSO, which is never above the written value.
    if (tmo_pkg::ONLY_TSO)
    begin
      mm_legal = tmo_pkg::MM_TSO;
    end
    else if (w == tmo_pkg::MM_RELAXED_ORDERING_MODEL || w == tmo_pkg::MM_TSO)
    begin
      mm_legal = w;
    end
    else
    begin
      mm_legal = tmo_pkg::MM_TSO;
    end
  endfunction

  logic [tmo_pkg::NTAG-1:0] done_vec;
  logic                     hazard;
  logic                     is_ld;
  logic                     is_st;

  always_comb
  begin
    done_vec = mem.d_done ? tag_bit(mem.d_done_tag) : '0;
    is_ld = (op_kind_in == tmo_pkg::OP_LOAD);
    is_st = (op_kind_in == tmo_pkg::OP_STORE);
    // The memory side serves one transaction at a time, yet ordered pairs never overlap.
    hazard = 1'b0;
    if (s_q.mm == tmo_pkg::MM_TSO)
    begin
      if (is_ld && (s_q.pend_ld != '0))
        hazard = 1'b1;
      if (is_st && (s_q.pend != '0))
        hazard = 1'b1;
      if (is_ld && store_to_load_barrier_in && (s_q.pend != '0))
        hazard = 1'b1;
      if (is_ld && (s_q.pend != '0) && (op_addr_in == s_q.addr))
        hazard = 1'b1;
    end
    else if (store_to_load_barrier_in && (s_q.pend != '0))
    begin
      hazard = 1'b1;
    end
    if (op_kind_in == tmo_pkg::OP_ATOMIC && (s_q.pend != '0))
      hazard = 1'b1;
    if (op_side_effect_in && (s_q.pend_se != '0))
      hazard = 1'b1;
    if ((s_q.pend & tag_bit(s_q.next_tag)) != '0)
      hazard = 1'b1;
  end

  always_comb
  begin
    s_d = s_q;
    s_d.ld_done = 1'b0;
    s_d.fault = 1'b0;
    s_d.ready = 1'b0;
    s_d.f_done = 1'b0;
    s_d.pend = s_q.pend & ~done_vec;
    s_d.pend_ld = s_q.pend_ld & ~done_vec;
    s_d.pend_se = s_q.pend_se & ~done_vec;
    if (mem.d_done && ((s_q.pend_ld & done_vec) != '0))
    begin
      s_d.ld_done = 1'b1;
      s_d.ld_data = mem.d_rdata;
    end
    if (mm_wr_in)
    begin
      s_d.mm = mm_legal(mm_wdata_in);
    end
    // Instruction fetch has its own path and never sees data-side stores early.
    s_d.i_req = fetch_in;
    s_d.i_addr = fetch_addr_in;
    if (mem.i_done)
    begin
      s_d.f_done = 1'b1;
      s_d.f_data = mem.i_rdata;
    end
    if (s_q.req && mem.d_acc)
    begin
      s_d.req = 1'b0;
      s_d.pend = s_d.pend | tag_bit(s_q.tag);
      s_d.pend_ld = s_d.pend_ld | (s_q.req_ld ? tag_bit(s_q.tag) : '0);
      s_d.pend_se = s_d.pend_se | (s_q.req_se ? tag_bit(s_q.tag) : '0);
    end
    case (s_q.st)
      tmo_pkg::TMO_IDLE:
      begin
        if (op_valid_in && !s_q.ready && !s_q.req)
        begin
          if (op_kind_in == tmo_pkg::OP_ATOMIC && !op_cacheable_in)
          begin
            s_d.fault = 1'b1;
            s_d.ready = 1'b1;
          end
          else if (op_internal_asi_in)
          begin
            s_d.st = tmo_pkg::TMO_DRAIN;
          end
          else if (!hazard)
          begin
            s_d.req = 1'b1;
            s_d.ready = 1'b1;
          end
        end
      end
      tmo_pkg::TMO_DRAIN:
      begin
        if (s_q.pend == '0 && !s_q.req)
        begin
          s_d.paused = 1'b1;
          s_d.st = tmo_pkg::TMO_PAUSE;
        end
      end
      tmo_pkg::TMO_PAUSE:
      begin
        s_d.req = 1'b1;
        s_d.ready = 1'b1;
        s_d.st = tmo_pkg::TMO_ACCESS;
      end
      tmo_pkg::TMO_ACCESS:
      begin
        if (!s_q.req && s_q.pend == '0)
        begin
          s_d.paused = 1'b0;
          s_d.st = tmo_pkg::TMO_IDLE;
        end
      end
      default:
      begin
        s_d.st = tmo_pkg::TMO_IDLE;
      end
    endcase
    if (s_d.req && !s_q.req)
    begin
      s_d.op = op_kind_in;
      s_d.tag = s_q.next_tag;
      s_d.next_tag = s_q.next_tag + tmo_pkg::TAG_W'(1);
      s_d.addr = op_addr_in;
      s_d.wdata = op_wdata_in;
      s_d.req_ld = (op_kind_in != tmo_pkg::OP_STORE);
      s_d.req_se = op_side_effect_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      s_q <= '0;
      s_q.st <= tmo_pkg::TMO_IDLE;
      s_q.mm <= tmo_pkg::MM_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign mem.d_req = s_q.req;
  assign mem.d_op = s_q.op;
  assign mem.d_tag = s_q.tag;
  assign mem.d_addr = s_q.addr;
  assign mem.d_wdata = s_q.wdata;
  assign mem.i_req = s_q.i_req;
  assign mem.i_addr = s_q.i_addr;
  assign mem.strands_paused = s_q.paused;
  assign memory_model_select_out = s_q.mm;
  assign op_ready_out = s_q.ready;
  assign op_fault_out = s_q.fault;
  assign load_done_out = s_q.ld_done;
  assign load_data_out = s_q.ld_data;
  assign fetch_done_out = s_q.f_done;
  assign fetch_data_out = s_q.f_data;
endmodule
`default_nettype wire

// file: verilog/tmo_pkg.sv
// Package with shared constants and types for the memory ordering unit.
package tmo_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int TAG_W  = 2;
  localparam int NTAG   = 4;
  localparam int MEM_WORDS = 16;
  localparam int MEM_IDX_W = 4;
  localparam logic [1:0] MM_TSO     = 2'h0;
  localparam logic [1:0] MM_PARTIAL_STORE_ORDERING_MODEL = 2'h1;
  localparam logic [1:0] MM_RELAXED_ORDERING_MODEL       = 2'h2;
  localparam logic [1:0] MM_IMPL    = 2'h3;
  localparam logic [1:0] MM_RESET   = 2'h0;
  localparam logic       ONLY_TSO   = 1'b0;
  localparam logic [1:0] OP_LOAD    = 2'h0;
  localparam logic [1:0] OP_STORE   = 2'h1;
  localparam logic [1:0] OP_ATOMIC  = 2'h2;
  localparam logic [1:0] OP_IFETCH  = 2'h3;
  localparam logic [3:0] SYNC_ASI_TOP = 4'hF;
  localparam int MEM_LAT_CYC = 2;
  localparam logic [1:0] LAT_RESET = 2'h0;
  typedef enum logic [3:0] {
    TMO_IDLE   = 4'b0001,
    TMO_DRAIN  = 4'b0010,
    TMO_PAUSE  = 4'b0100,
    TMO_ACCESS = 4'b1000
  } tmo_state_t;
endpackage
